// ---- cbt_params.svh ----
// Register offsets, field positions and timing constants of the bit timer.
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH
`define CBT_ADDR_PRESCALE  3'h0
`define CBT_ADDR_JUMP_PROP 3'h1
`define CBT_ADDR_PHASE     3'h2
`define CBT_ADDR_CTRL      3'h3
`define CBT_ADDR_STATUS    3'h4
`define CBT_PRESC_MSB      6
`define CBT_PRESC_LSB      1
`define CBT_RJW_MSB        6
`define CBT_RJW_LSB        5
`define CBT_PROP_MSB       3
`define CBT_PROP_LSB       1
`define CBT_PH2_MSB        6
`define CBT_PH2_LSB        4
`define CBT_PH1_MSB        3
`define CBT_PH1_LSB        1
`define CBT_TRIPLE_BIT     0
`define CBT_CKMODE_BIT     0
`define CBT_CFG_RESET      19'h00000
`define CBT_IDLE_BITS      4'hb
`define CBT_SYS_HZ_FAST    20000000
`define CBT_SYS_HZ_SLOW    10000000
`define CBT_CLKDIV_SLOW    (`CBT_SYS_HZ_FAST / `CBT_SYS_HZ_SLOW)
`endif

// ---- cbt_pkg.sv ----
// Types shared by the bit-timing block.
package cbt_pkg;
	typedef enum logic [1:0] {
		CBT_SEG_SYNC,
		CBT_SEG_PROP,
		CBT_SEG_PH1,
		CBT_SEG_PH2
	} cbt_seg_t;

	typedef struct packed {
		logic [5:0] baud_prescaler;
		logic [1:0] resync_jump_width;
		logic [2:0] prop_seg;
		logic [2:0] phase_segment_two;
		logic [2:0] phase_segment_one;
		logic       triple_sample_select;
		logic       clock_mode;
	} cbt_cfg_t;

	typedef struct packed {
		cbt_cfg_t   cfg;
		cbt_seg_t   seg;
		logic [3:0] cnt;
		logic [2:0] ext;
		logic       resynced;
		logic       idle;
		logic [3:0] rec_cnt;
		logic [1:0] rx_sync;
		logic       rx_prev;
		logic [1:0] div_cnt;
		logic [7:0] rd_data;
	} cbt_main_st_t;
endpackage : cbt_pkg

// ---- cbt_quantum_gen.sv ----
// Prescaler that turns system clock enables into quantum ticks.
`timescale 1ns/1ns
module cbt_quantum_gen (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_sys_en,
	input  wire logic       i_restart,
	input  wire logic [5:0] i_baud_prescaler,
	output logic            o_quantum_tick,
	output logic            o_half_tick
);
	typedef struct packed {
		logic [5:0] cnt;
		logic [5:0] chk;
	} cbt_qg_st_t;

	cbt_qg_st_t q;
	cbt_qg_st_t d;

	// A lowered prescaler ends the running quantum at once, never wraps.
	always_comb begin
		d = q;
		o_quantum_tick = i_sys_en && !i_restart && (q.cnt >= i_baud_prescaler);
		o_half_tick = i_sys_en && !i_restart && (i_baud_prescaler != 6'h00)
			&& (q.cnt == (i_baud_prescaler >> 1));
		if (i_restart || o_quantum_tick) begin
			d.cnt = 6'h00;
			d.chk = 6'h00;
		end else if (i_sys_en) begin
			d.cnt = q.cnt + 6'h01;
			d.chk = q.chk + 6'h01;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	a_quantum_len: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_quantum_tick && $stable(i_baud_prescaler) |-> q.chk == i_baud_prescaler)
		else $error("quantum length differs from prescaler plus one");
endmodule : cbt_quantum_gen

// ---- cbt_sampler.sv ----
// Bus sampler with single or majority-of-three decision.
`timescale 1ns/1ns
module cbt_sampler (
	input  wire logic i_ref_clk,
	input  wire logic i_rst,
	input  wire logic i_level,
	input  wire logic i_shift,
	input  wire logic i_sample,
	input  wire logic i_triple,
	output logic      o_bit,
	output logic      o_valid
);
	typedef struct packed {
		logic [1:0] hist;
		logic       bitv;
		logic       valid;
	} cbt_smp_st_t;

	cbt_smp_st_t q;
	cbt_smp_st_t d;

	always_comb begin
		d = q;
		d.valid = 1'b0;
		if (i_shift) begin
			d.hist = {q.hist[0], i_level};
		end
		if (i_sample) begin
			d.valid = 1'b1;
			// With a non-zero prescaler, older samples sit half a quantum and one quantum back.
			d.bitv = i_triple ? ((q.hist[1] & q.hist[0]) | (q.hist[1] & i_level)
				| (q.hist[0] & i_level)) : i_level;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			q <= '0;
			q.hist <= 2'h3;
			q.bitv <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign o_bit = q.bitv;
	assign o_valid = q.valid;

	a_single_sample: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_sample && !i_triple |=> o_valid && o_bit == $past(i_level))
		else $error("single sample does not follow bus level");
	a_triple_vote: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_sample && i_triple && q.hist[1] == q.hist[0] |=> o_bit == $past(q.hist[0]))
		else $error("majority vote outvoted by one sample");
endmodule : cbt_sampler

// ---- cbt_bit_timer.sv ----
// Bit-timing unit: registers, clock mode, segment sequencer and sync.
`timescale 1ns/1ns
`include "cbt_params.svh"

module cbt_bit_timer (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic [2:0] i_addr,
	input  wire logic [7:0] i_wr_data,
	input  wire logic       i_wr_en,
	input  wire logic       i_rd_en,
	input  wire logic       i_can_rx,
	output logic      [7:0] o_rd_data,
	output logic            o_rx_bit,
	output logic            o_rx_valid,
	output logic            o_sample_point,
	output logic            o_bus_idle
);
	cbt_pkg::cbt_main_st_t q;
	cbt_pkg::cbt_main_st_t d;

	logic       sys_en;
	logic       quantum_tick;
	logic       half_tick;
	logic       fall_edge;
	logic       hard_sync;
	logic       restart;
	logic       sample_pt;
	logic [3:0] cnt_v;
	logic [2:0] ext_v;
	logic [4:0] rjw1;
	logic [4:0] elapsed;
	logic [4:0] remain;
	logic [4:0] ph1_end;

	// ==========================================================
	// System clock rate
	// The reference clock stands for the fast system clock; the slow
	// mode keeps one enable out of every divider period.
	// rate selection
	assign sys_en = q.cfg.clock_mode
		|| (q.div_cnt == 2'(`CBT_CLKDIV_SLOW - 1));

	// ==========================================================
	// Bus edge detection
	// Only recessive-to-dominant edges are used for synchronisation.
	assign fall_edge = q.rx_prev && !q.rx_sync[1];
	assign hard_sync = fall_edge && q.idle;

	cbt_quantum_gen u_quantum (
		.i_ref_clk        (i_ref_clk),
		.i_rst            (i_rst),
		.i_sys_en         (sys_en),
		.i_restart        (restart),
		.i_baud_prescaler (q.cfg.baud_prescaler),
		.o_quantum_tick   (quantum_tick),
		.o_half_tick      (half_tick)
	);

	cbt_sampler u_sampler (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_level   (q.rx_sync[1]),
		.i_shift   (quantum_tick || half_tick),
		.i_sample  (sample_pt),
		.i_triple  (q.cfg.triple_sample_select),
		.o_bit     (o_rx_bit),
		.o_valid   (o_rx_valid)
	);

	// ==========================================================
	// Next-state logic
	always_comb begin
		d = q;
		cnt_v = q.cnt;
		ext_v = q.ext;
		restart = 1'b0;
		sample_pt = 1'b0;
		rjw1 = {3'h0, q.cfg.resync_jump_width} + 5'h01;
		elapsed = 5'h00;
		remain = 5'h00;
		ph1_end = 5'h00;

		d.rx_sync = {q.rx_sync[0], i_can_rx};
		d.rx_prev = q.rx_sync[1];
		if (q.cfg.clock_mode || sys_en) begin
			d.div_cnt = 2'h0;
		end else begin
			d.div_cnt = q.div_cnt + 2'h1;
		end

		// Register writes; unused bits are not stored.
		if (i_wr_en) begin
			case (i_addr)
				`CBT_ADDR_PRESCALE: begin
					d.cfg.baud_prescaler =
						i_wr_data[`CBT_PRESC_MSB:`CBT_PRESC_LSB];
				end
				`CBT_ADDR_JUMP_PROP: begin
					d.cfg.resync_jump_width =
						i_wr_data[`CBT_RJW_MSB:`CBT_RJW_LSB];
					d.cfg.prop_seg = i_wr_data[`CBT_PROP_MSB:`CBT_PROP_LSB];
				end
				`CBT_ADDR_PHASE: begin
					d.cfg.phase_segment_two =
						i_wr_data[`CBT_PH2_MSB:`CBT_PH2_LSB];
					d.cfg.phase_segment_one =
						i_wr_data[`CBT_PH1_MSB:`CBT_PH1_LSB];
					d.cfg.triple_sample_select = i_wr_data[`CBT_TRIPLE_BIT];
				end
				`CBT_ADDR_CTRL: begin
					d.cfg.clock_mode = i_wr_data[`CBT_CKMODE_BIT];
				end
				default: begin
				end
			endcase
		end

		// Read data stand for exactly one cycle after the strobe.
		d.rd_data = 8'h00;
		if (i_rd_en) begin
			case (i_addr)
				`CBT_ADDR_PRESCALE: begin
					d.rd_data = {1'b0, q.cfg.baud_prescaler, 1'b0};
				end
				`CBT_ADDR_JUMP_PROP: begin
					d.rd_data = {1'b0, q.cfg.resync_jump_width, 1'b0,
						q.cfg.prop_seg, 1'b0};
				end
				`CBT_ADDR_PHASE: begin
					d.rd_data = {1'b0, q.cfg.phase_segment_two,
						q.cfg.phase_segment_one, q.cfg.triple_sample_select};
				end
				`CBT_ADDR_CTRL: begin
					d.rd_data = {7'h00, q.cfg.clock_mode};
				end
				`CBT_ADDR_STATUS: begin
					d.rd_data = {4'h0, q.seg, o_rx_bit, q.idle};
				end
				default: begin
					d.rd_data = 8'h00;
				end
			endcase
		end

		// Soft resynchronisation, at most once per bit.
		if (hard_sync) begin
			restart = 1'b1;
		end else if (fall_edge && !q.resynced
			&& q.seg != cbt_pkg::CBT_SEG_SYNC) begin
			d.resynced = 1'b1;
			if (q.seg == cbt_pkg::CBT_SEG_PH2) begin
				remain = {2'h0, q.cfg.phase_segment_two} - {1'b0, q.cnt}
					+ 5'h01;
				if (remain <= rjw1) begin
					restart = 1'b1;
				end else begin
					cnt_v = q.cnt + rjw1[3:0];
				end
			end else begin
				if (q.seg == cbt_pkg::CBT_SEG_PROP) begin
					elapsed = {1'b0, q.cnt} + 5'h01;
				end else begin
					elapsed = {2'h0, q.cfg.prop_seg} + {1'b0, q.cnt} + 5'h02;
				end
				ext_v = (elapsed < rjw1) ? elapsed[2:0] : rjw1[2:0];
			end
		end

		d.cnt = cnt_v;
		d.ext = ext_v;
		ph1_end = {2'h0, q.cfg.phase_segment_one} + {2'h0, ext_v};
		if (restart) begin
			// The edge itself opens a fresh sync quantum.
			d.seg = cbt_pkg::CBT_SEG_SYNC;
			d.cnt = 4'h0;
			d.ext = 3'h0;
			d.resynced = 1'b1;
			if (hard_sync) begin
				d.idle = 1'b0;
				d.rec_cnt = 4'h0;
			end
		end else if (quantum_tick) begin
			case (q.seg)
				cbt_pkg::CBT_SEG_SYNC: begin
					d.seg = cbt_pkg::CBT_SEG_PROP;
					d.cnt = 4'h0;
					d.resynced = 1'b0;
				end
				cbt_pkg::CBT_SEG_PROP: begin
					if (cnt_v >= {1'b0, q.cfg.prop_seg}) begin
						d.seg = cbt_pkg::CBT_SEG_PH1;
						d.cnt = 4'h0;
					end else begin
						d.cnt = cnt_v + 4'h1;
					end
				end
				// sample point at phase one end
				cbt_pkg::CBT_SEG_PH1: begin
					if ({1'b0, cnt_v} >= ph1_end) begin
						d.seg = cbt_pkg::CBT_SEG_PH2;
						d.cnt = 4'h0;
						d.ext = 3'h0;
						sample_pt = 1'b1;
					end else begin
						d.cnt = cnt_v + 4'h1;
					end
				end
				cbt_pkg::CBT_SEG_PH2: begin
					if (cnt_v >= {1'b0, q.cfg.phase_segment_two}) begin
						d.seg = cbt_pkg::CBT_SEG_SYNC;
						d.cnt = 4'h0;
					end else begin
						d.cnt = cnt_v + 4'h1;
					end
				end
				default: begin
					d.seg = cbt_pkg::CBT_SEG_SYNC;
					d.cnt = 4'h0;
				end
			endcase
		end

		// Idle after a run of recessive bits, so the next edge hard-syncs.
		if (o_rx_valid && !hard_sync) begin
			if (!o_rx_bit) begin
				d.rec_cnt = 4'h0;
				d.idle = 1'b0;
			end else if (q.rec_cnt < `CBT_IDLE_BITS) begin
				d.rec_cnt = q.rec_cnt + 4'h1;
				if (q.rec_cnt + 4'h1 == `CBT_IDLE_BITS) begin
					d.idle = 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			q <= '0;
			q.cfg <= `CBT_CFG_RESET;
			q.idle <= 1'b1;
			q.rx_sync <= 2'h3;
			q.rx_prev <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign o_rd_data = q.rd_data;
	assign o_sample_point = sample_pt;
	assign o_bus_idle = q.idle;

	// ==========================================================
	// Checks
	a_fast_rate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		q.cfg.clock_mode |-> sys_en)
		else $error("fast mode misses a system enable");
	a_slow_rate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!q.cfg.clock_mode && sys_en |=> !sys_en || q.cfg.clock_mode)
		else $error("slow mode enables two cycles in a row");
	a_prescale_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_rd_en && i_addr == `CBT_ADDR_PRESCALE
		|=> o_rd_data == {1'b0, $past(q.cfg.baud_prescaler), 1'b0})
		else $error("prescaler register reads wrong");
	a_prescale_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_wr_en && i_addr == `CBT_ADDR_PRESCALE
		|=> q.cfg.baud_prescaler == $past(i_wr_data[6:1]))
		else $error("prescaler write not stored");
	a_jump_prop_map: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_wr_en && i_addr == `CBT_ADDR_JUMP_PROP ##1 i_rd_en
		&& i_addr == `CBT_ADDR_JUMP_PROP |=> o_rd_data == ($past(i_wr_data, 2) & 8'h6e))
		else $error("jump and propagation fields misplaced");
	a_phase_map: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_wr_en && i_addr == `CBT_ADDR_PHASE ##1 i_rd_en
		&& i_addr == `CBT_ADDR_PHASE |=> o_rd_data == ($past(i_wr_data, 2) & 8'h7f))
		else $error("phase and sampling fields misplaced");
	a_sync_one_tq: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		q.seg == cbt_pkg::CBT_SEG_SYNC && quantum_tick && !restart
		|=> q.seg == cbt_pkg::CBT_SEG_PROP && q.cnt == 4'h0)
		else $error("sync segment longer than one quantum");
	a_ph2_length: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		q.seg == cbt_pkg::CBT_SEG_PH2 && quantum_tick && !fall_edge
		&& q.cnt == {1'b0, q.cfg.phase_segment_two}
		|=> q.seg == cbt_pkg::CBT_SEG_SYNC)
		else $error("phase two does not end after field plus one");
	a_sample_place: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		sample_pt |-> q.seg == cbt_pkg::CBT_SEG_PH1 && quantum_tick
		##1 q.seg == cbt_pkg::CBT_SEG_PH2 && o_rx_valid)
		else $error("sample point off the phase boundary");
	a_hard_sync: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		fall_edge && q.idle
		|=> q.seg == cbt_pkg::CBT_SEG_SYNC && q.cnt == 4'h0 && !q.idle)
		else $error("frame start edge did not hard-sync");
	a_jump_limit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		q.ext <= {1'b0, q.cfg.resync_jump_width} + 3'h1)
		else $error("resync jump exceeds jump width");
endmodule : cbt_bit_timer

// ---- cbt_bus_node.sv ----
// Bus node model that drives frames onto the receive line of the bit timer.
`timescale 1ns/1ns
module cbt_bus_node (
	input  wire logic i_ref_clk,
	output logic      o_can_tx
);
	// =========================================================
	// Frame driver
	// The released bus floats back to recessive, as the bus
	// termination would pull it.
	initial o_can_tx = 1'b1;

	// node bit timing
	// Every bit stands one full bit period so that each edge lands
	// on a bit start of the receiver after its hard sync.
	task automatic send(input logic [15:0] bits, input int n, input int t);
		for (int k = 0; k < n; k++) begin
			@(posedge i_ref_clk);
			o_can_tx <= bits[k];
			repeat (t - 1) @(posedge i_ref_clk);
		end
		@(posedge i_ref_clk);
		o_can_tx <= 1'b1;
	endtask : send
endmodule : cbt_bus_node

// ---- testbench.sv ----
// Self-checking bench for the bit timer with a bus node on the far side.
`timescale 1ns/1ns
module testbench;
	logic        i_ref_clk   = 1'b0;
	logic        i_rst       = 1'b1;
	logic [2:0]  i_addr      = 3'h0;
	logic [7:0]  i_wr_data   = 8'h00;
	logic        i_wr_en     = 1'b0;
	logic        i_rd_en     = 1'b0;
	logic        can_line;
	logic [7:0]  o_rd_data;
	logic        o_rx_bit;
	logic        o_rx_valid;
	logic        o_sample_point;
	logic        o_bus_idle;
	int          err_total   = 0;
	int          checks_done = 0;
	int          seed        = 32'h8fb4;
	int          cyc         = 0;
	int          t0          = 0;
	int          last_sp     = 0;
	int          bit_t       = 0;
	bit          armed       = 1'b0;
	logic        exp_q [$];
	logic [7:0]  d;
	logic [7:0]  v;
	logic [15:0] frame;
	// Read-back masks of addresses 0 to 7; address 4 is read only.
	logic [7:0]  mask [8] = '{8'h7e, 8'h6e, 8'h7f, 8'h01,
	                          8'h00, 8'h00, 8'h00, 8'h00};
	// configurations kept legal by software
	// Columns: prescaler, prop, phase one, phase two, clock mode, triple.
	int          cfg [4][6] = '{'{0, 1, 1, 3, 1, 0}, '{2, 2, 3, 2, 0, 1},
	                           '{24, 2, 7, 7, 1, 0}, '{63, 0, 3, 3, 0, 1}};

	always #50 i_ref_clk = ~i_ref_clk;

	cbt_bit_timer i_cbt_bit_timer (
		.i_ref_clk      (i_ref_clk),
		.i_rst          (i_rst),
		.i_addr         (i_addr),
		.i_wr_data      (i_wr_data),
		.i_wr_en        (i_wr_en),
		.i_rd_en        (i_rd_en),
		.i_can_rx       (can_line),
		.o_rd_data      (o_rd_data),
		.o_rx_bit       (o_rx_bit),
		.o_rx_valid     (o_rx_valid),
		.o_sample_point (o_sample_point),
		.o_bus_idle     (o_bus_idle)
	);

	cbt_bus_node i_cbt_bus_node (
		.i_ref_clk (i_ref_clk),
		.o_can_tx  (can_line)
	);

	// =========================================================
	// Shared tasks
	task automatic check(input string n, input logic [15:0] e,
	                     input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : check

	task automatic wr(input logic [2:0] a, input logic [7:0] x);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wr_data <= x;
		i_wr_en <= 1'b1;
		@(posedge i_ref_clk);
		i_wr_en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [7:0] x);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd_en <= 1'b1;
		@(posedge i_ref_clk);
		i_rd_en <= 1'b0;
		#1 x = o_rd_data;
	endtask : rd

	// A write and a read of the same register on back-to-back cycles.
	task automatic wr_rd(input logic [2:0] a, input logic [7:0] x,
	                     output logic [7:0] y);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wr_data <= x;
		i_wr_en <= 1'b1;
		@(posedge i_ref_clk);
		i_wr_en <= 1'b0;
		i_rd_en <= 1'b1;
		@(posedge i_ref_clk);
		i_rd_en <= 1'b0;
		#1 y = o_rd_data;
	endtask : wr_rd

	task automatic wrap_up;
		if (err_total == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	// =========================================================
	// Model side: bit period and sampled bits
	// Pulses in the first cycles after the frame starts are skipped,
	// because they come from timing that ran before the hard sync.
	// Sampled on the falling edge, where the design's outputs are settled.
	always @(negedge i_ref_clk) begin
		cyc++;
		if (armed && cyc - t0 > 5 && o_sample_point === 1'b1) begin
			if (last_sp > 0)
				check("bit period", 16'(bit_t), 16'(cyc - last_sp));
			last_sp = cyc;
		end
		if (armed && cyc - t0 > 6 && o_rx_valid === 1'b1 && exp_q.size() > 0)
			check("rx bit", 16'(exp_q.pop_front()), 16'(o_rx_bit));
	end

	initial begin
		repeat (60000) @(posedge i_ref_clk);
		err_total++;
		wrap_up();
	end

	// =========================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), d);
			check("reset value", (a == 4) ? 16'h0003 : 16'h0000,
			      16'(d & ((a == 4) ? 8'hf3 : 8'hff)));
		end
		for (int a = 0; a < 8; a++) begin
			if (a != 4) begin
				v = 8'($random(seed));
				wr_rd(3'(a), v, d);
				check("read back", 16'(v & mask[a]), 16'(d));
			end
		end
		for (int c = 0; c < 4; c++) begin
			armed = 1'b0;
			i_rst <= 1'b1;
			repeat (2) @(posedge i_ref_clk);
			i_rst <= 1'b0;
			wr(3'h0, 8'(cfg[c][0] << 1));
			wr(3'h1, 8'(cfg[c][1] << 1));
			wr(3'h2, 8'((cfg[c][3] << 4) | (cfg[c][2] << 1) | cfg[c][5]));
			wr(3'h3, 8'(cfg[c][4]));
			bit_t = (4 + cfg[c][1] + cfg[c][2] + cfg[c][3])
			        * (cfg[c][0] + 1) * (2 - cfg[c][4]);
			// Dominant first and last bits frame the random payload.
			frame = 16'($random(seed)) & 16'h01fe;
			for (int k = 0; k < 10; k++)
				exp_q.push_back(frame[k]);
			last_sp = 0;
			t0 = cyc;
			armed = 1'b1;
			i_cbt_bus_node.send(frame, 10, bit_t);
			repeat (10 * bit_t) @(posedge i_ref_clk);
			#1;
			check("idle early", 16'h0000, 16'(o_bus_idle));
			repeat (2 * bit_t) @(posedge i_ref_clk);
			#1;
			check("idle late", 16'h0001, 16'(o_bus_idle));
			check("bits left", 16'h0000, 16'(exp_q.size()));
			rd(3'h4, d);
			check("status", 16'h0003, 16'(d & 8'hf3));
		end
		wrap_up();
	end
endmodule : testbench
